// ==== verilog/ucrm_pkg.sv ====
// register map, field layout, reset values and carriers for the
// dual channel serial controller register file.
// assumes one core clock; host pins and modem pins are asynchronous.
`default_nettype none

package ucrm_pkg;

  // ********************************************************
  // channel count and register locations
  // ********************************************************
  localparam int NUM_CH = 2;
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_IER_DIVH = 3'h1;
  localparam logic [2:0] ADDR_ISR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SPR = 3'h7;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  localparam int LCR_DLAB = 7;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OP1 = 2;
  localparam int MCR_OP2 = 3;
  localparam int MCR_LOOP = 4;

  // ********************************************************
  // interrupt source codes and reset values
  // ********************************************************
  localparam logic [3:0] ISR_LINE = 4'h6;
  localparam logic [3:0] ISR_RXRDY = 4'h4;
  localparam logic [3:0] ISR_TXRDY = 4'h2;
  localparam logic [3:0] ISR_MODEM = 4'h0;
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [3:0] IER_RST = 4'h0;
  localparam logic [4:0] MCR_RST = 5'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] SPR_RST = 8'h00;

  // ********************************************************
  // carriers
  // ********************************************************
  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} ucrm_bus_state_t;

  typedef struct packed {
    logic [1:0] cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } ucrm_hbus_t;

  localparam ucrm_hbus_t HBUS_IDLE = '{cs_n: 2'h3, rd_n: 1'b1,
                                       wr_n: 1'b1, default: '0};

  typedef struct packed {
    logic carrier_detect_n;
    logic ring_indicate_n;
    logic set_ready_n;
    logic clear_to_send_n;
  } ucrm_modem_in_t;

  typedef struct packed {
    logic push;
    logic [7:0] data;
    logic parity_err;
    logic framing_err;
    logic brk;
  } ucrm_rx_ev_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ucrm_tx_t;

  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0] line_control;
    logic loopback;
  } ucrm_cfg_t;

  typedef struct packed {
    logic terminal_ready_n;
    logic request_to_send_n;
    logic general_output_one_n;
    logic general_output_two_n;
  } ucrm_modem_out_t;

  typedef struct packed {
    logic [7:0] transmit_holding;
    logic thr_full;
    logic [7:0] receive_holding;
    logic rx_ready;
    logic overrun;
    logic parity_err;
    logic framing_err;
    logic brk_seen;
    logic [3:0] interrupt_enable;
    logic [7:0] line_control;
    logic [4:0] modem_control;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] scratch_pad;
    logic [3:0] mprev;
    logic [3:0] mdelta;
    logic tx_int;
    logic irq;
    logic dtr_n;
    logic rts_n;
    logic op1_n;
    logic op2_n;
  } ucrm_chan_t;

  localparam ucrm_chan_t CHAN_RST = '{interrupt_enable: IER_RST,
                                      line_control: LCR_RST,
                                      modem_control: MCR_RST,
                                      divisor_low: DIV_RST,
                                      divisor_high: DIV_RST,
                                      scratch_pad: SPR_RST,
                                      dtr_n: 1'b1, rts_n: 1'b1,
                                      op1_n: 1'b1, op2_n: 1'b1,
                                      default: '0};

  // highest pending source wins; line status first, modem last
  function automatic logic [3:0] chan_isr(input ucrm_chan_t s);
    logic line_err;
    line_err = s.overrun | s.parity_err | s.framing_err | s.brk_seen;
    if (s.interrupt_enable[IER_LS] && line_err)
      return ISR_LINE;
    else if (s.interrupt_enable[IER_RX] && s.rx_ready)
      return ISR_RXRDY;
    else if (s.interrupt_enable[IER_TX] && s.tx_int)
      return ISR_TXRDY;
    else if (s.interrupt_enable[IER_MS] && (|s.mdelta))
      return ISR_MODEM;
    else
      return ISR_NONE;
  endfunction

endpackage

`default_nettype wire

// ==== verilog/ucrm_sync.sv ====
// multi-bit two flip-flop synchroniser for asynchronous levels.
// assumes each bit is an independent level; words are not coherent.
`default_nettype none

module ucrm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter int STAGES = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] stage_q [STAGES];
  logic [W-1:0] stage_d [STAGES];

  if (STAGES < 2) begin : g_bad
    $error("ucrm_sync needs at least two stages");
  end

  // first stage feeds only the second one
  always_comb
  begin
    stage_d[0] = async_i;
    for (int i = 1; i < STAGES; i++)
    begin
      stage_d[i] = stage_q[i-1];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < STAGES; i++)
      begin
        stage_q[i] <= RST_VAL;
      end
    end
    else
    begin
      stage_q <= stage_d;
    end
  end

  assign sync_o = stage_q[STAGES-1];

endmodule

`default_nettype wire

// ==== verilog/ucrm_dual_regs.sv ====
// host register file and decode for both serial channels.
// assumes the host strobes are slow against core_clk and that the
// transmitter, receiver and baud logic run on core_clk behind it.
`default_nettype none

module ucrm_dual_regs
  import ucrm_pkg::*;
#(
  // arbitrary values, not tied to any real part
  parameter logic [7:0] DEV_REVISION = 8'h01,
  parameter logic [7:0] DEV_IDENT = 8'h5a
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_n,
  input wire ucrm_modem_in_t [NUM_CH-1:0] modem_in,
  input wire ucrm_rx_ev_t [NUM_CH-1:0] rx_ev,
  input wire logic [NUM_CH-1:0] tx_take,
  input wire logic [NUM_CH-1:0] tx_shifter_empty,
  output ucrm_tx_t [NUM_CH-1:0] tx_out,
  output ucrm_cfg_t [NUM_CH-1:0] cfg_out,
  output ucrm_modem_out_t [NUM_CH-1:0] modem_out,
  output logic [NUM_CH-1:0] irq
);

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  ucrm_hbus_t pins_raw;
  ucrm_hbus_t hb;
  ucrm_modem_in_t [NUM_CH-1:0] ms_sync;

  assign pins_raw = '{cs_n: {channel_b_select_n, channel_a_select_n},
                      rd_n: host_read_n,
                      wr_n: host_write_n,
                      addr: host_addr,
                      data: host_data_i};

  ucrm_sync #(
    .W($bits(ucrm_hbus_t)),
    .RST_VAL(HBUS_IDLE),
    .STAGES(2)
  ) u_bus_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_i(pins_raw),
    .sync_o(hb)
  );

  // modem inputs idle deasserted (high) out of reset
  ucrm_sync #(
    .W($bits(ucrm_modem_in_t) * NUM_CH),
    .RST_VAL('1),
    .STAGES(2)
  ) u_modem_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_i(modem_in),
    .sync_o(ms_sync)
  );

  // ********************************************************
  // host strobe sequencing
  // ********************************************************
  ucrm_bus_state_t bus_state_q, bus_state_d;
  logic sel_q, sel_d;
  logic [2:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] dout_q, dout_d;
  logic oe_n_q, oe_n_d;
  logic [NUM_CH-1:0] rd_go;
  logic [NUM_CH-1:0] wr_go;
  logic [7:0] rd_val [NUM_CH];
  logic cs_any;
  logic cs_idx;

  // a read is served at strobe entry so side effects come after
  // the byte is latched; a write lands at strobe release, using
  // the data last seen while the strobe was still low
  always_comb
  begin
    bus_state_d = bus_state_q;
    sel_d = sel_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    dout_d = dout_q;
    oe_n_d = oe_n_q;
    rd_go = '0;
    wr_go = '0;
    cs_any = ~hb.cs_n[0] | ~hb.cs_n[1];
    cs_idx = hb.cs_n[0];
    unique case (bus_state_q)
      BUS_IDLE:
      begin
        if (cs_any && !hb.rd_n)
        begin
          bus_state_d = BUS_READ;
          sel_d = cs_idx;
          addr_d = hb.addr;
          dout_d = rd_val[cs_idx];
          oe_n_d = 1'b0;
          rd_go[cs_idx] = 1'b1;
        end
        else if (cs_any && !hb.wr_n)
        begin
          bus_state_d = BUS_WRITE;
          sel_d = cs_idx;
          addr_d = hb.addr;
          wdata_d = hb.data;
        end
      end
      BUS_READ:
      begin
        if (hb.rd_n)
        begin
          bus_state_d = BUS_IDLE;
          oe_n_d = 1'b1;
        end
      end
      BUS_WRITE:
      begin
        if (hb.wr_n)
        begin
          bus_state_d = BUS_IDLE;
          wr_go[sel_q] = 1'b1;
        end
        else
        begin
          wdata_d = hb.data;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_state_q <= BUS_IDLE;
      sel_q <= 1'b0;
      addr_q <= 3'h0;
      wdata_q <= 8'h00;
      dout_q <= 8'h00;
      oe_n_q <= 1'b1;
    end
    else
    begin
      bus_state_q <= bus_state_d;
      sel_q <= sel_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign host_data_o = dout_q;
  assign host_data_oe_n = oe_n_q;

  // ********************************************************
  // per channel registers
  // ********************************************************
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    ucrm_chan_t q, d;
    logic [3:0] mstate;
    logic dlab;
    logic div_zero;
    logic rhr_rd;
    logic thr_wr;

    // loopback feeds the modem outputs back as modem inputs
    always_comb
    begin
      if (q.modem_control[MCR_LOOP])
      begin
        mstate = {q.modem_control[MCR_OP2], q.modem_control[MCR_OP1],
                  q.modem_control[MCR_DTR], q.modem_control[MCR_RTS]};
      end
      else
      begin
        mstate = ~ms_sync[c];
      end
    end

    assign dlab = q.line_control[LCR_DLAB];
    assign div_zero = (q.divisor_low == 8'h00) &&
                      (q.divisor_high == 8'h00);

    // read view; hb.addr is the location being entered this cycle
    always_comb
    begin
      unique case (hb.addr)
        ADDR_HOLD:
        begin
          if (dlab)
            rd_val[c] = div_zero ? DEV_REVISION : q.divisor_low;
          else
            rd_val[c] = q.receive_holding;
        end
        ADDR_IER_DIVH:
        begin
          if (dlab)
            rd_val[c] = div_zero ? DEV_IDENT : q.divisor_high;
          else
            rd_val[c] = {4'h0, q.interrupt_enable};
        end
        ADDR_ISR: rd_val[c] = {4'h0, chan_isr(q)};
        ADDR_LCR: rd_val[c] = q.line_control;
        ADDR_MCR: rd_val[c] = {3'h0, q.modem_control};
        ADDR_LSR:
        begin
          rd_val[c] = {1'b0, ~q.thr_full & tx_shifter_empty[c],
                       ~q.thr_full, q.brk_seen, q.framing_err,
                       q.parity_err, q.overrun, q.rx_ready};
        end
        ADDR_MSR: rd_val[c] = {mstate, q.mdelta};
        ADDR_SPR: rd_val[c] = q.scratch_pad;
      endcase
    end

    // clears are applied first and events after, so an event in
    // the clearing cycle survives
    always_comb
    begin
      d = q;
      rhr_rd = rd_go[c] && (hb.addr == ADDR_HOLD) && !dlab;
      thr_wr = wr_go[c] && (addr_q == ADDR_HOLD) && !dlab;
      d.mprev = mstate;
      if (rd_go[c])
      begin
        unique case (hb.addr)
          ADDR_HOLD:
          begin
            if (!dlab)
            begin
              d.rx_ready = 1'b0;
              d.parity_err = 1'b0;
              d.framing_err = 1'b0;
              d.brk_seen = 1'b0;
            end
          end
          ADDR_ISR:
          begin
            if (chan_isr(q) == ISR_TXRDY)
              d.tx_int = 1'b0;
          end
          ADDR_LSR:
          begin
            d.overrun = 1'b0;
            d.parity_err = 1'b0;
            d.framing_err = 1'b0;
            d.brk_seen = 1'b0;
          end
          ADDR_MSR: d.mdelta = 4'h0;
          ADDR_IER_DIVH, ADDR_LCR, ADDR_MCR, ADDR_SPR:
          begin
          end
        endcase
      end
      if (wr_go[c])
      begin
        unique case (addr_q)
          ADDR_HOLD:
          begin
            if (dlab)
            begin
              d.divisor_low = wdata_q;
            end
            else
            begin
              d.transmit_holding = wdata_q;
              d.thr_full = 1'b1;
              d.tx_int = 1'b0;
            end
          end
          ADDR_IER_DIVH:
          begin
            if (dlab)
              d.divisor_high = wdata_q;
            else
              d.interrupt_enable = wdata_q[3:0];
          end
          ADDR_LCR: d.line_control = wdata_q;
          ADDR_MCR: d.modem_control = wdata_q[4:0];
          ADDR_SPR: d.scratch_pad = wdata_q;
          ADDR_ISR, ADDR_LSR, ADDR_MSR:
          begin
            // read-only locations swallow writes
          end
        endcase
      end
      // a refill in the same cycle keeps the holding register full
      if (tx_take[c] && !thr_wr)
      begin
        d.thr_full = 1'b0;
        d.tx_int = 1'b1;
      end
      if (d.interrupt_enable[IER_TX] && !q.interrupt_enable[IER_TX] &&
          !d.thr_full)
      begin
        d.tx_int = 1'b1;
      end
      if (rx_ev[c].push)
      begin
        d.overrun = d.overrun | (q.rx_ready & ~rhr_rd);
        d.receive_holding = rx_ev[c].data;
        d.rx_ready = 1'b1;
        d.parity_err = rx_ev[c].parity_err;
        d.framing_err = rx_ev[c].framing_err;
        d.brk_seen = rx_ev[c].brk;
      end
      d.mdelta = d.mdelta | (mstate ^ q.mprev);
      d.irq = d.modem_control[MCR_OP2] & (chan_isr(d) != ISR_NONE);
      d.dtr_n = d.modem_control[MCR_LOOP] | ~d.modem_control[MCR_DTR];
      d.rts_n = d.modem_control[MCR_LOOP] | ~d.modem_control[MCR_RTS];
      d.op1_n = d.modem_control[MCR_LOOP] | ~d.modem_control[MCR_OP1];
      d.op2_n = d.modem_control[MCR_LOOP] | ~d.modem_control[MCR_OP2];
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        q <= CHAN_RST;
      end
      else
      begin
        q <= d;
      end
    end

    assign tx_out[c].valid = q.thr_full;
    assign tx_out[c].data = q.transmit_holding;
    assign cfg_out[c].divisor = {q.divisor_high, q.divisor_low};
    assign cfg_out[c].line_control = q.line_control;
    assign cfg_out[c].loopback = q.modem_control[MCR_LOOP];
    assign modem_out[c].terminal_ready_n = q.dtr_n;
    assign modem_out[c].request_to_send_n = q.rts_n;
    assign modem_out[c].general_output_one_n = q.op1_n;
    assign modem_out[c].general_output_two_n = q.op2_n;
    assign irq[c] = q.irq;
  end

endmodule

`default_nettype wire

// ==== tb/ucrm_dual_regs_monitor.sv ====
// concurrent checks on the host and back-end ports of the register file.
// assumes the host keeps the access spacing of the host model.
`default_nettype none

module ucrm_dual_regs_monitor
  import ucrm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_o,
  input wire logic host_data_oe_n,
  input wire logic [NUM_CH-1:0] tx_take,
  input wire ucrm_tx_t [NUM_CH-1:0] tx_out,
  input wire ucrm_cfg_t [NUM_CH-1:0] cfg_out,
  input wire ucrm_modem_out_t [NUM_CH-1:0] modem_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************************************
  // idle counters since channel b select and write strobe
  // ********************************************************
  logic [3:0] b_idle_q, b_idle_d, w_idle_q, w_idle_d;

  always_comb
  begin
    b_idle_d = (b_idle_q == 4'hf) ? b_idle_q : b_idle_q + 4'h1;
    w_idle_d = (w_idle_q == 4'hf) ? w_idle_q : w_idle_q + 4'h1;
    if (!channel_b_select_n)
      b_idle_d = 4'h0;
    if (!host_write_n)
      w_idle_d = 4'h0;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      b_idle_q <= 4'h0;
      w_idle_q <= 4'h0;
    end
    else
    begin
      b_idle_q <= b_idle_d;
      w_idle_q <= w_idle_d;
    end
  end

  // ********************************************************
  // properties
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence rd_start;
    $fell(host_read_n) && !channel_a_select_n;
  endsequence
  sequence bus_on;
    ##3 !host_data_oe_n;
  endsequence

  oe_open_a: assert property (rd_start |-> bus_on)
    else $error("read did not open the data bus");
  oe_cause_a: assert property ($fell(host_data_oe_n)
    |-> !$past(host_read_n, 3))
    else $error("data bus opened without a read");
  data_hold_a: assert property (!host_read_n && !host_data_oe_n
    |=> !host_data_oe_n && $stable(host_data_o))
    else $error("read data moved during strobe");
  oe_close_a: assert property ($rose(host_read_n)
    |-> ##[2:4] host_data_oe_n)
    else $error("data bus not released");
  write_quiet_a: assert property (!host_write_n |-> host_data_oe_n)
    else $error("data bus driven during write");
  take_clear_a: assert property (tx_take[0] && w_idle_q > 4'h6
    |=> !tx_out[0].valid)
    else $error("holding byte not released");
  valid_src_a: assert property ($rose(tx_out[0].valid) |-> host_write_n
    && host_addr == ADDR_HOLD && !channel_a_select_n
    && !cfg_out[0].line_control[LCR_DLAB])
    else $error("holding loaded without a write at location 0");
  chan_sep_a: assert property (b_idle_q > 4'h9
    |=> $stable(cfg_out[1]) && $stable(modem_out[1]))
    else $error("channel b changed without its select");
  loop_quiet_a: assert property (cfg_out[0].loopback
    && $past(cfg_out[0].loopback) |-> modem_out[0] == 4'hf)
    else $error("modem outputs active in loopback");
endmodule

`default_nettype wire

// ==== tb/ucrm_host_model.sv ====
// host processor on the asynchronous register bus, one access a call.
// assumes the tb resolves the data wire from the device output enable.
`default_nettype none

module ucrm_host_model
  import ucrm_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] bus,
  output ucrm_hbus_t hb
);
  timeunit 1ns;
  timeprecision 1ns;

  initial hb = HBUS_IDLE;

  // select and address settle two clocks before the strobe, and stay
  // well past its rise so the synchronisers never see a torn access
  task automatic acc(input logic ch, input logic wr, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    hb.cs_n <= ch ? 2'h1 : 2'h2;
    hb.addr <= a;
    hb.data <= d;
    repeat (2) @(posedge core_clk);
    if (wr)
      hb.wr_n <= 1'b0;
    else
      hb.rd_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    q = bus;
    hb.rd_n <= 1'b1;
    hb.wr_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    hb.cs_n <= 2'h3;
    hb.data <= ~d;
    repeat (3) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the dual channel register file.
// assumes the host model above and the monitor bound below.
`default_nettype none

module tb
  import ucrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] REV = 8'h03; // arbitrary value
  localparam logic [7:0] IDN = 8'h7e; // arbitrary value
  logic core_clk, reset_n, host_data_oe_n;
  logic [7:0] host_data_o, bus, q;
  ucrm_hbus_t hb;
  ucrm_modem_in_t [NUM_CH-1:0] modem_in;
  ucrm_rx_ev_t [NUM_CH-1:0] rx_ev;
  logic [NUM_CH-1:0] tx_take, tx_se, irq;
  ucrm_tx_t [NUM_CH-1:0] tx_out;
  ucrm_cfg_t [NUM_CH-1:0] cfg_out;
  ucrm_modem_out_t [NUM_CH-1:0] modem_out;
  int err_total = 0;
  int check_count = 0;

  // ********************************************************
  // wiring
  // ********************************************************
  assign bus = !host_data_oe_n ? host_data_o : hb.data;
  ucrm_host_model host (.core_clk(core_clk), .bus(bus), .hb(hb));
  ucrm_dual_regs #(.DEV_REVISION(REV), .DEV_IDENT(IDN)) uut (
    .core_clk(core_clk), .reset_n(reset_n),
    .channel_a_select_n(hb.cs_n[0]), .channel_b_select_n(hb.cs_n[1]),
    .host_read_n(hb.rd_n), .host_write_n(hb.wr_n), .host_addr(hb.addr),
    .host_data_i(bus), .host_data_o(host_data_o),
    .host_data_oe_n(host_data_oe_n), .modem_in(modem_in), .rx_ev(rx_ev),
    .tx_take(tx_take), .tx_shifter_empty(tx_se), .tx_out(tx_out),
    .cfg_out(cfg_out), .modem_out(modem_out), .irq(irq));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
    host.acc(c, 1'b1, a, d, q);
  endtask
  task automatic rc(input logic c, input logic [2:0] a, input logic [7:0] e,
                    input string n);
    host.acc(c, 1'b0, a, 8'h00, q);
    chk(n, {8'h00, q}, {8'h00, e});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset;
    logic [7:0] ev [8];
    ev = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++)
      rc(1'b0, 3'(i), ev[i], "reset value");
    chk("modem out", {12'h000, modem_out[0]}, 16'h000f);
    chk("irq", {14'h0000, irq}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_scratch;
    logic [2:0] ro [3];
    ro = '{ADDR_ISR, ADDR_LSR, ADDR_MSR};
    wr(1'b0, ADDR_SPR, 8'ha5);
    wr(1'b1, ADDR_SPR, 8'h5a);
    rc(1'b0, ADDR_SPR, 8'ha5, "scratch a");
    rc(1'b1, ADDR_SPR, 8'h5a, "scratch b");
    foreach (ro[i])
      wr(1'b0, ro[i], 8'hff);
    rc(1'b0, ADDR_ISR, 8'h01, "status after write");
    rc(1'b0, ADDR_LSR, 8'h60, "line after write");
    chk("line cfg", {8'h00, cfg_out[0].line_control}, 16'h0000);
    $display("test scratch done");
  endtask

  task automatic t_divisor;
    wr(1'b0, ADDR_LCR, 8'h80);
    rc(1'b0, ADDR_HOLD, REV, "revision");
    rc(1'b0, ADDR_IER_DIVH, IDN, "identifier");
    wr(1'b0, ADDR_HOLD, 8'h34);
    wr(1'b0, ADDR_IER_DIVH, 8'h12);
    rc(1'b0, ADDR_HOLD, 8'h34, "divisor low");
    rc(1'b0, ADDR_IER_DIVH, 8'h12, "divisor high");
    chk("divisor", cfg_out[0].divisor, 16'h1234);
    chk("divisor b", cfg_out[1].divisor, 16'h0000);
    chk("no tx load", {15'h0000, tx_out[0].valid}, 16'h0000);
    wr(1'b0, ADDR_LCR, 8'h7f);
    rc(1'b0, ADDR_LCR, 8'h7f, "line control");
    chk("line cfg", {8'h00, cfg_out[0].line_control}, 16'h007f);
    rc(1'b0, ADDR_IER_DIVH, 8'h00, "enables back");
    wr(1'b0, ADDR_LCR, 8'h00);
    $display("test divisor done");
  endtask

  task automatic t_tx;
    wr(1'b0, ADDR_IER_DIVH, 8'hff);
    rc(1'b0, ADDR_IER_DIVH, 8'h0f, "enables");
    wr(1'b0, ADDR_IER_DIVH, 8'h02);
    rc(1'b0, ADDR_ISR, 8'h02, "tx empty int");
    rc(1'b0, ADDR_ISR, 8'h01, "tx int read");
    wr(1'b0, ADDR_HOLD, 8'h3c);
    chk("tx out", {7'h00, tx_out[0]}, 16'h013c);
    rc(1'b0, ADDR_LSR, 8'h00, "tx busy");
    @(posedge core_clk);
    tx_take[0] <= 1'b1;
    tx_se[0] <= 1'b0;
    @(posedge core_clk);
    tx_take[0] <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("tx taken", {15'h0000, tx_out[0].valid}, 16'h0000);
    rc(1'b0, ADDR_LSR, 8'h20, "shifter busy");
    tx_se[0] <= 1'b1;
    rc(1'b0, ADDR_ISR, 8'h02, "tx int again");
    wr(1'b0, ADDR_IER_DIVH, 8'h00);
    $display("test transmit done");
  endtask

  task automatic t_rx;
    wr(1'b0, ADDR_MCR, 8'h08);
    wr(1'b0, ADDR_IER_DIVH, 8'h05);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge core_clk);
      rx_ev[0] <= '{push: 1'b1, data: 8'h11 * 8'(i + 1) + 8'h55,
                    parity_err: 1'(i), framing_err: 1'(i), brk: 1'(i)};
      @(posedge core_clk);
      rx_ev[0] <= '0;
    end
    repeat (2) @(posedge core_clk);
    chk("irq line", {14'h0000, irq}, 16'h0001);
    rc(1'b0, ADDR_ISR, 8'h06, "line int");
    rc(1'b0, ADDR_LSR, 8'h7f, "line errors");
    rc(1'b0, ADDR_ISR, 8'h04, "rx int");
    rc(1'b0, ADDR_HOLD, 8'h77, "rx data");
    rc(1'b0, ADDR_ISR, 8'h01, "rx int read");
    rc(1'b0, ADDR_LSR, 8'h60, "line clear");
    chk("irq clear", {14'h0000, irq}, 16'h0000);
    $display("test receive done");
  endtask

  task automatic t_modem;
    wr(1'b0, ADDR_MCR, 8'h03);
    chk("modem pins", {12'h000, modem_out[0]}, 16'h0003);
    rc(1'b0, ADDR_MCR, 8'h03, "modem control");
    wr(1'b0, ADDR_MCR, 8'hff);
    rc(1'b0, ADDR_MCR, 8'h1f, "modem control high");
    chk("loopback", {15'h0000, cfg_out[0].loopback}, 16'h0001);
    wr(1'b0, ADDR_MCR, 8'h08);
    wr(1'b0, ADDR_IER_DIVH, 8'h08);
    // loopback round trip leaves all four deltas set
    rc(1'b0, ADDR_MSR, 8'h0f, "loop deltas");
    modem_in[0].clear_to_send_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("irq modem", {14'h0000, irq}, 16'h0001);
    rc(1'b0, ADDR_ISR, 8'h00, "modem int");
    rc(1'b0, ADDR_MSR, 8'h11, "modem status");
    rc(1'b0, ADDR_MSR, 8'h10, "modem steady");
    rc(1'b0, ADDR_ISR, 8'h01, "modem int read");
    $display("test modem done");
  endtask

  // ********************************************************
  // main sequence and watchdog
  // ********************************************************
  initial
  begin
    reset_n = 1'b0;
    modem_in = '1;
    rx_ev = '0;
    tx_take = '0;
    tx_se = '1;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_scratch();
    t_divisor();
    t_tx();
    t_rx();
    t_modem();
    results();
  end

  initial
  begin
    #400000;
    err_total++;
    $display("watchdog expired");
    results();
  end
endmodule

bind ucrm_dual_regs ucrm_dual_regs_monitor mon (
  .core_clk, .reset_n, .channel_a_select_n, .channel_b_select_n,
  .host_read_n, .host_write_n, .host_addr, .host_data_o,
  .host_data_oe_n, .tx_take, .tx_out, .cfg_out, .modem_out);

`default_nettype wire
